// ### rtl/rbc_defines.svh
// register offsets, field positions and reset values of the rtc control block
`ifndef RBC_DEFINES_SVH
`define RBC_DEFINES_SVH

// ==========================================
// register offsets (4-bit register index)
`define RBC_OFS_BANK 4'h0
`define RBC_OFS_RST 4'h1
`define RBC_OFS_TIME_A 4'h2
`define RBC_OFS_TIME_B 4'h3
`define RBC_OFS_ALM_DAY 4'h4
`define RBC_OFS_ALM_WDAY 4'h5
`define RBC_OFS_IRQ_STAT 4'h8
`define RBC_OFS_IRQ_EN 4'h9
`define RBC_OFS_IRQ_CLR 4'ha

// ==========================================
// bank_select_and_enable fields
`define RBC_BANK_IRQ_EN 7
`define RBC_BANK_ADJUST 4
`define RBC_BANK_RUN_EN 3
`define RBC_BANK_ALM_EN 2
`define RBC_BANK_SEL 0

// ==========================================
// counter_reset_and_rate_select fields
`define RBC_RST_DIS1 7
`define RBC_RST_DIS16 6
`define RBC_RST_SECRST 5
`define RBC_RST_ALMRST 4
`define RBC_RST_LOW_RST 3'h7

// ==========================================
// interrupt status bits
`define RBC_IRQ_ADJ_DONE 0
`define RBC_IRQ_SRST_DONE 1
`define RBC_IRQ_SRC_EVT 2

// ==========================================
// time values and alarm reset values
`define RBC_PRESC_W 15
`define RBC_SEC_MAX 6'h3b
`define RBC_SEC_HALF 6'h1e
`define RBC_ALM_MIN_RST 6'h00
`define RBC_ALM_HOUR_RST 5'h00
`define RBC_ALM_DAY_RST 6'h01
`define RBC_ALM_WDAY_RST 3'h0

`endif

// ### rtl/rbc_pkg.sv
// types shared by the rtc control block
package rbc_pkg;

  // ==========================================
  // control fields of the bank register
  typedef struct packed {
    logic irq_en;
    logic run_en;
    logic alm_en;
    logic bank;
  } rbc_ctl_t;

  // ==========================================
  // rate and reset fields
  typedef struct packed {
    logic dis1;
    logic dis16;
    logic [2:0] low;
  } rbc_rate_t;

  // interrupt source choice
  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_ALARM = 2'b01,
    SRC_1HZ = 2'b10,
    SRC_16HZ = 2'b11
  } rbc_src_t;

  // state of the low pulse on the interrupt line
  typedef enum logic {
    PULSE_IDLE = 1'b0,
    PULSE_LOW = 1'b1
  } rbc_pulse_t;

endpackage

// ### rtl/rbc_sync.sv
// three-stage synchroniser with rising edge pulse for the low-speed clock pin
module rbc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pin and result
  input wire logic pin,
  output logic rise
);

  logic [2:0] ff_r;
  logic [2:0] ff_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic rise_r;
  logic rise_nxt;

  // level accepted once stages two and three agree
  always_comb begin
    ff_nxt = {ff_r[1:0], pin};
    lvl_nxt = lvl_r;
    rise_nxt = 1'b0;
    if (ff_r[1] == ff_r[2]) begin
      lvl_nxt = ff_r[2];
      rise_nxt = ff_r[2] & ~lvl_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ff_r <= 3'h0;
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
    end else begin
      ff_r <= ff_nxt;
      lvl_r <= lvl_nxt;
      rise_r <= rise_nxt;
    end
  end

  assign rise = rise_r;

endmodule

// ### rtl/rbc_top.sv
// rtc bank select, enable, counter reset and interrupt source control
// ==========================================
`include "rbc_defines.svh"
module rbc_top
  import rbc_pkg::*;
#(
  parameter int PRESC_W = `RBC_PRESC_W,
  parameter bit LOW_BITS_RW = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // low-speed clock pin
  input wire logic lsc_pin,
  // register port
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // interrupts and pins
  output logic irq,
  output logic rtc_irq_n,
  output logic alarm_n
);

  // ==========================================
  // elaboration check
  if (PRESC_W < 5 || PRESC_W > 24) begin : g_chk
    $error("prescaler width out of range");
  end

  // ==========================================
  // state
  rbc_ctl_t ctl_r, ctl_nxt;
  rbc_rate_t rate_r, rate_nxt;
  rbc_pulse_t pulse_r, pulse_nxt;
  logic adj_pend_r, adj_pend_nxt;
  logic srst_pend_r, srst_pend_nxt;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic [5:0] sec_r, sec_nxt;
  logic [5:0] min_r, min_nxt;
  logic [5:0] amin_r, amin_nxt;
  logic [4:0] ahour_r, ahour_nxt;
  logic [5:0] aday_r, aday_nxt;
  logic [2:0] awday_r, awday_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic [2:0] ien_r, ien_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic rtc_irq_n_r;
  logic alarm_n_r;

  // ==========================================
  // combinational helpers
  logic lsc_rise;
  logic sec_tick;
  logic tick16;
  logic alm_hit;
  logic src_evt;
  logic adj_done;
  logic srst_done;
  rbc_src_t src;
  logic wr_bank;
  logic wr_rst;

  // low-speed clock from its pin
  rbc_sync i_rbc_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pin(lsc_pin),
    .rise(lsc_rise)
  );

  // ==========================================
  // prescaler and ticks
  always_comb begin
    presc_nxt = presc_r;
    srst_pend_nxt = srst_pend_r;
    srst_done = 1'b0;
    sec_tick = 1'b0;
    tick16 = 1'b0;
    if (lsc_rise) begin
      if (srst_pend_r) begin
        presc_nxt = '0;
        srst_pend_nxt = 1'b0;
        srst_done = 1'b1;
      end else begin
        presc_nxt = presc_r + 1'b1;
        sec_tick = &presc_r;
        tick16 = &presc_r[PRESC_W-5:0];
      end
    end
    // a new request wins over completion
    if (wr_rst && wdata[`RBC_RST_SECRST]) begin
      srst_pend_nxt = 1'b1;
    end
  end

  // ==========================================
  // bus decode
  assign wr_bank = wr && (addr == `RBC_OFS_BANK);
  assign wr_rst = wr && (addr == `RBC_OFS_RST);

  // ==========================================
  // control registers and time counters
  always_comb begin
    ctl_nxt = ctl_r;
    rate_nxt = rate_r;
    adj_pend_nxt = adj_pend_r;
    sec_nxt = sec_r;
    min_nxt = min_r;
    amin_nxt = amin_r;
    ahour_nxt = ahour_r;
    aday_nxt = aday_r;
    awday_nxt = awday_r;
    adj_done = 1'b0;
    alm_hit = 1'b0;
    // count only while the clock runs
    if (sec_tick && ctl_r.run_en) begin
      if (adj_pend_r) begin
        sec_nxt = 6'h00;
        if (sec_r >= `RBC_SEC_HALF) begin
          min_nxt = (min_r == `RBC_SEC_MAX) ? 6'h00 : min_r + 6'h01;
        end
        adj_pend_nxt = 1'b0;
        adj_done = 1'b1;
      end else if (sec_r == `RBC_SEC_MAX) begin
        sec_nxt = 6'h00;
        min_nxt = (min_r == `RBC_SEC_MAX) ? 6'h00 : min_r + 6'h01;
      end else begin
        sec_nxt = sec_r + 6'h01;
      end
      alm_hit = (sec_nxt == 6'h00) && (min_nxt == amin_r);
    end
    // bank register write
    if (wr_bank) begin
      ctl_nxt.irq_en = wdata[`RBC_BANK_IRQ_EN];
      ctl_nxt.run_en = wdata[`RBC_BANK_RUN_EN];
      ctl_nxt.alm_en = wdata[`RBC_BANK_ALM_EN];
      ctl_nxt.bank = wdata[`RBC_BANK_SEL];
      if (wdata[`RBC_BANK_ADJUST]) begin
        adj_pend_nxt = 1'b1;
      end
    end
    // reset register write
    if (wr_rst) begin
      rate_nxt.dis1 = wdata[`RBC_RST_DIS1];
      rate_nxt.dis16 = wdata[`RBC_RST_DIS16];
      rate_nxt.low = LOW_BITS_RW ? wdata[2:0] : 3'h0;
      if (wdata[`RBC_RST_ALMRST]) begin
        amin_nxt = `RBC_ALM_MIN_RST;
        ahour_nxt = `RBC_ALM_HOUR_RST;
        aday_nxt = `RBC_ALM_DAY_RST;
        awday_nxt = `RBC_ALM_WDAY_RST;
      end
    end
    // time or alarm digits by bank
    if (wr && !ctl_r.bank) begin
      if (addr == `RBC_OFS_TIME_A) begin
        sec_nxt = wdata[5:0];
      end
      if (addr == `RBC_OFS_TIME_B) begin
        min_nxt = wdata[5:0];
      end
    end
    if (wr && ctl_r.bank) begin
      case (addr)
        `RBC_OFS_TIME_A: amin_nxt = wdata[5:0];
        `RBC_OFS_TIME_B: ahour_nxt = wdata[4:0];
        `RBC_OFS_ALM_DAY: aday_nxt = wdata[5:0];
        `RBC_OFS_ALM_WDAY: awday_nxt = wdata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================
  // interrupt source selection and pulse
  always_comb begin
    case ({rate_r.dis1, rate_r.dis16, ctl_r.alm_en})
      3'b111: src = SRC_ALARM;
      3'b010: src = SRC_1HZ;
      3'b100: src = SRC_16HZ;
      default: src = SRC_NONE;
    endcase
    case (src)
      SRC_ALARM: src_evt = alm_hit;
      SRC_1HZ: src_evt = sec_tick;
      SRC_16HZ: src_evt = tick16;
      default: src_evt = 1'b0;
    endcase
    src_evt = src_evt & ctl_r.irq_en;
    pulse_nxt = pulse_r;
    case (pulse_r)
      PULSE_IDLE: begin
        if (src_evt) begin
          pulse_nxt = PULSE_LOW;
        end
      end
      PULSE_LOW: begin
        if (lsc_rise) begin
          pulse_nxt = PULSE_IDLE;
        end
      end
      default: pulse_nxt = PULSE_IDLE;
    endcase
  end

  // ==========================================
  // sticky status, enable and level interrupt
  always_comb begin
    ien_nxt = ien_r;
    stat_nxt = stat_r;
    if (wr && addr == `RBC_OFS_IRQ_EN) begin
      ien_nxt = wdata[2:0];
    end
    if (wr && addr == `RBC_OFS_IRQ_CLR) begin
      stat_nxt = stat_r & ~wdata[2:0];
    end
    // a new event beats a clear
    stat_nxt[`RBC_IRQ_ADJ_DONE] = stat_nxt[`RBC_IRQ_ADJ_DONE] | adj_done;
    stat_nxt[`RBC_IRQ_SRST_DONE] = stat_nxt[`RBC_IRQ_SRST_DONE] | srst_done;
    stat_nxt[`RBC_IRQ_SRC_EVT] = stat_nxt[`RBC_IRQ_SRC_EVT] | src_evt;
    irq_nxt = |(stat_nxt & ien_nxt);
  end

  // ==========================================
  // read data, valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = 8'h00;
    if (rd) begin
      case (addr)
        `RBC_OFS_BANK: rdata_nxt = {ctl_r.irq_en, 2'b00, adj_pend_r, ctl_r.run_en,
                                    ctl_r.alm_en, 1'b0, ctl_r.bank};
        `RBC_OFS_RST: rdata_nxt = {rate_r.dis1, rate_r.dis16, srst_pend_r, 2'b00,
                                   rate_r.low};
        `RBC_OFS_TIME_A: rdata_nxt = ctl_r.bank ? {2'b00, amin_r} : {2'b00, sec_r};
        `RBC_OFS_TIME_B: rdata_nxt = ctl_r.bank ? {3'b000, ahour_r} : {2'b00, min_r};
        `RBC_OFS_ALM_DAY: rdata_nxt = ctl_r.bank ? {2'b00, aday_r} : 8'h00;
        `RBC_OFS_ALM_WDAY: rdata_nxt = ctl_r.bank ? {5'h00, awday_r} : 8'h00;
        `RBC_OFS_IRQ_STAT: rdata_nxt = {5'h00, stat_r};
        `RBC_OFS_IRQ_EN: rdata_nxt = {5'h00, ien_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_r <= '0;
      rate_r <= '{dis1: 1'b1, dis16: 1'b1, low: 3'h0};
      pulse_r <= PULSE_IDLE;
      adj_pend_r <= 1'b0;
      srst_pend_r <= 1'b0;
      presc_r <= '0;
      sec_r <= 6'h00;
      min_r <= 6'h00;
      amin_r <= `RBC_ALM_MIN_RST;
      ahour_r <= `RBC_ALM_HOUR_RST;
      aday_r <= `RBC_ALM_DAY_RST;
      awday_r <= `RBC_ALM_WDAY_RST;
      stat_r <= 3'h0;
      ien_r <= 3'h0;
      rdata_r <= 8'h00;
      irq_r <= 1'b0;
      rtc_irq_n_r <= 1'b1;
      alarm_n_r <= 1'b1;
    end else begin
      ctl_r <= ctl_nxt;
      rate_r <= rate_nxt;
      pulse_r <= pulse_nxt;
      adj_pend_r <= adj_pend_nxt;
      srst_pend_r <= srst_pend_nxt;
      presc_r <= presc_nxt;
      sec_r <= sec_nxt;
      min_r <= min_nxt;
      amin_r <= amin_nxt;
      ahour_r <= ahour_nxt;
      aday_r <= aday_nxt;
      awday_r <= awday_nxt;
      stat_r <= stat_nxt;
      ien_r <= ien_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      rtc_irq_n_r <= (pulse_nxt != PULSE_LOW);
      alarm_n_r <= (pulse_nxt != PULSE_LOW);
    end
  end

  // ==========================================
  // outputs
  assign rdata = rdata_r;
  assign irq = irq_r;
  assign rtc_irq_n = rtc_irq_n_r;
  assign alarm_n = alarm_n_r;

endmodule

// ### verif/rbc_top_props.sv
// port assertions of the rtc control block
module rbc_top_props (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port and pin
  input wire logic lsc_pin,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // interrupt outputs
  input wire logic irq,
  input wire logic rtc_irq_n,
  input wire logic alarm_n
);
  // ==========================================
  // shadows of written control bits
  logic bank_r;
  logic irq_en_r;
  logic [2:0] ien_r;
  // follow bank, irq enable and status enable writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_r <= 1'b0;
      irq_en_r <= 1'b0;
      ien_r <= 3'h0;
    end else if (wr && addr == 4'h0) begin
      bank_r <= wdata[0];
      irq_en_r <= wdata[7];
    end else if (wr && addr == 4'h9) begin
      ien_r <= wdata[2:0];
    end
  end
  // ==========================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_fall;
    $fell(rtc_irq_n);
  endsequence
  sequence s_low;
    !rtc_irq_n [*4];
  endsequence
  AST_PIN_PAIR: assert property (rtc_irq_n == alarm_n)
    else $error("alarm pin differs from irq pin");
  AST_PULSE_LEN: assert property (s_fall |-> s_low ##[1:20] rtc_irq_n)
    else $error("irq pulse length wrong");
  AST_GATE: assert property (s_fall |-> $past(irq_en_r))
    else $error("pulse while irq enable low");
  AST_IRQ_MASK: assert property (ien_r == 3'h0 && $past(ien_r) == 3'h0 |-> !irq)
    else $error("irq high with all enables low");
  AST_UNMAPPED: assert property (rd && addr == 4'h7 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_BANK_RSVD: assert property (rd && addr == 4'h0 |=> rdata[6:5] == 2'h0 && !rdata[1])
    else $error("bank reserved bits not zero");
  AST_RST_RSVD: assert property (rd && addr == 4'h1 |=> rdata[4:3] == 2'h0)
    else $error("reset register bits 4:3 not zero");
  AST_PAGE0_GAP: assert property (rd && addr == 4'h4 && !bank_r |=> rdata == 8'h00)
    else $error("page0 index 4 not zero");
  AST_RD_IDLE: assert property (!rd |=> rdata == 8'h00)
    else $error("rdata not zero outside read");
endmodule

// ### verif/rbc_top_tb.sv
// self-checking bench of the rtc control block
module rbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PW = 6;
  localparam int SLOW = 8; // clk cycles per low-speed period
  logic clk;
  logic rst_n;
  logic lsc_pin;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic irq;
  logic rtc_irq_n;
  logic alarm_n;
  int fails;
  int samples_checked;
  int n;
  // ==========================================
  // device under test
  rbc_top #(.PRESC_W(PW), .LOW_BITS_RW(1'b0)) i_rbc_top (
    .clk(clk), .rst_n(rst_n), .lsc_pin(lsc_pin), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .rtc_irq_n(rtc_irq_n),
    .alarm_n(alarm_n)
  );
  // system clock and low-speed clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    lsc_pin = 1'b0;
    forever #100 lsc_pin = ~lsc_pin;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd_reg(a, v);
    chk({8'h00, v}, {8'h00, exp});
  endtask
  // read status until bit b is set
  task automatic poll(input int b);
    logic [7:0] v;
    int k;
    v = 8'h00;
    k = 0;
    while (v[b] !== 1'b1 && k < 600) begin
      rd_reg(4'h8, v);
      k++;
    end
    chk({15'h0, v[b]}, 16'h1);
  endtask
  // count clk edges up to the next falling edge of rtc_irq_n
  task automatic wait_fall(input int lim, output int cnt);
    cnt = 0;
    while (rtc_irq_n !== 1'b1 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
    while (rtc_irq_n !== 1'b0 && cnt < lim) begin
      @(posedge clk);
      #1;
      cnt++;
    end
  endtask
  task automatic summarize;
    $display("checks=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize();
  end
  // ==========================================
  // main sequence
  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(4'h0, 8'h00);
    rd_chk(4'h1, 8'hc0);
    rd_chk(4'h7, 8'h00);
    rd_chk(4'h4, 8'h00);
    // reserved bits, bank 1 and alarm reset
    wr_reg(4'h0, 8'h6f);
    rd_chk(4'h0, 8'h0d);
    rd_chk(4'h4, 8'h01);
    for (int i = 2; i < 6; i++) wr_reg(4'(i), 8'h03);
    wr_reg(4'h1, 8'hd0);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, 8'h00);
    rd_chk(4'h4, 8'h01);
    rd_chk(4'h5, 8'h00);
    rd_chk(4'h1, 8'hc0);
    // stopped clock keeps adjust pending
    wr_reg(4'h0, 8'h00);
    wr_reg(4'h3, 8'h07);
    wr_reg(4'h2, 8'h2d);
    wr_reg(4'h0, 8'h10);
    repeat (1100) @(posedge clk);
    rd_chk(4'h2, 8'h2d);
    rd_chk(4'h0, 8'h10);
    wr_reg(4'h0, 8'h00);
    rd_chk(4'h0, 8'h10);
    // upper half adjust then lower half adjust
    wr_reg(4'h0, 8'h18);
    poll(0);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, 8'h08);
    rd_chk(4'h0, 8'h08);
    wr_reg(4'ha, 8'h07);
    wr_reg(4'h2, 8'h0a);
    wr_reg(4'h0, 8'h18);
    poll(0);
    rd_chk(4'h2, 8'h00);
    rd_chk(4'h3, 8'h08);
    // seconds counter reset
    wr_reg(4'h1, 8'he0);
    poll(1);
    rd_chk(4'h1, 8'hc0);
    wr_reg(4'ha, 8'h07);
    // 1 hz source, gated then enabled
    wr_reg(4'h1, 8'h40);
    wait_fall(600, n);
    chk(16'(n), 16'd600);
    wr_reg(4'h9, 8'h04);
    wr_reg(4'h0, 8'h88);
    wait_fall(1100, n);
    wait_fall(1100, n);
    chk(16'(n), 16'((1 << PW) * SLOW));
    chk({15'h0, irq}, 16'h1);
    wr_reg(4'ha, 8'h04);
    repeat (2) @(posedge clk);
    #1;
    chk({15'h0, irq}, 16'h0);
    // 16 hz source
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h1, 8'h80);
    wr_reg(4'h0, 8'h88);
    wait_fall(1100, n);
    wait_fall(1100, n);
    chk(16'(n), 16'((1 << (PW - 4)) * SLOW));
    // undefined combination gives no pulse
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h1, 8'h00);
    wr_reg(4'h0, 8'h88);
    wait_fall(1100, n);
    chk(16'(n), 16'd1100);
    // alarm source: minute match at the next second wrap
    wr_reg(4'h0, 8'h09);
    wr_reg(4'h2, 8'h05);
    wr_reg(4'h0, 8'h08);
    wr_reg(4'h3, 8'h04);
    wr_reg(4'h1, 8'hc0);
    wr_reg(4'h0, 8'h0c);
    wr_reg(4'h0, 8'h8c);
    wr_reg(4'h2, 8'h3b);
    wait_fall(1100, n);
    chk({15'h0, rtc_irq_n}, 16'h0);
    rd_chk(4'h3, 8'h05);
    wait_fall(1100, n);
    chk(16'(n), 16'd1100);
    summarize();
  end
endmodule

bind rbc_top rbc_top_props i_rbc_top_props (
  .clk(clk), .rst_n(rst_n), .lsc_pin(lsc_pin), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .rtc_irq_n(rtc_irq_n),
  .alarm_n(alarm_n)
);
